// ===== rtl/spi_switch_command_port.sv
// serial command port of a dual-channel high-side switch
// Contract
// - words are 16 bits, shifted MSB first on input and output
// - bit 15 is the watchdog toggle bit, not configuration data
// - bit 14 makes the count of ones in the whole word even
// - bit 13 bank, bits 12..10 address, bits 9..0 payload
// - several words may follow in one chip-select-low period
// - wrong length or bad parity at chip select rise discards the transfer
// - output shifts MSB first from chip select fall while input is sampled
// - first 16 output bits are the register chosen by the previous selection
// - at chip select rise a valid payload is written to the addressed register
// - after the write output floats and the status word is refreshed
// - in a chain input bits leave the output one 16-bit word later
// - thirteen input and output registers; per-channel functions duplicated
// - in normal mode temperature over prewarning sets the fault word flag
// - flag clears only on a fault report read after temperature fell
// - status bits 0 and 1 show each channel's on state live
// - offset sign bit 8 of retry register picks sense offset polarity
// - track-and-hold keeps the sign active at switch-off while off
// - bank zero routes to channel 0, bank one to channel 1
`timescale 1ns/1ps
`include "switch_port_regs.svh"
module spi_switch_command_port
    import switch_port_pkg::*;
#(
    parameter int CHANNELS = 2
) (
    input  wire logic                clk,
    input  wire logic                rst_n,
    input  wire logic                sclk,
    input  wire logic                chip_select_n,
    input  wire logic                si_pin,
    output logic                     so_out,
    output logic                     so_oe,
    input  wire logic                reset_n_pin,
    input  wire logic                normal_mode,
    input  wire logic                temp_over_warn,
    input  wire logic [CHANNELS-1:0] channel_out_high,
    input  wire logic [6:0]          status_misc,
    input  wire logic [5:0]          fault_bits [CHANNELS],
    output logic                     watchdog_toggle_bit,
    output logic                     temp_prewarning_flag,
    output logic [CHANNELS-1:0]      offset_sign_select,
    output logic [CHANNELS-1:0]      sense_offset_sign,
    output logic                     track_hold_en,
    output cfg_write_s               cfg_write
);
    // ---------------- link domain (serial clock) ----------------
    logic            frame_reg;
    logic [3:0]      bit_cnt_reg;
    logic            word_seen_reg;
    logic [15:0]     rx_sr_reg;
    logic [3:0]      tx_idx;
    logic            so_bit;
    logic            frame_clr_n;
    so_word_s        out_word_reg;

    // frame flag is cleared by chip select itself, since the serial clock
    // stops between frames and cannot end the frame on its own
    assign frame_clr_n = rst_n & ~chip_select_n;

    always_ff @(posedge sclk or negedge frame_clr_n) begin
        if (!frame_clr_n) begin
            frame_reg <= 1'b0;
        end else begin
            frame_reg <= 1'b1;
        end
    end

    always_ff @(posedge sclk or negedge rst_n) begin
        if (!rst_n) begin
            bit_cnt_reg   <= 4'h0;
            word_seen_reg <= 1'b0;
        end else begin
            bit_cnt_reg   <= frame_reg ? bit_cnt_reg + 4'h1 : 4'h1;
            word_seen_reg <= frame_reg ? (word_seen_reg | (bit_cnt_reg == 4'hf)) : 1'b0;
        end
    end

    always_ff @(posedge sclk or negedge rst_n) begin
        if (!rst_n) begin
            rx_sr_reg <= 16'h0000;
        end else begin
            rx_sr_reg <= {rx_sr_reg[14:0], si_pin};
        end
    end

    // first word comes from the prepared output word, later ones from the
    // input bits sixteen edges ago
    assign tx_idx = frame_reg ? bit_cnt_reg : 4'h0;
    assign so_bit = (frame_reg && word_seen_reg) ? rx_sr_reg[15] :
                    out_word_reg[4'hf - tx_idx];
    assign so_out = so_bit;
    assign so_oe  = ~chip_select_n & rst_n;

    chk_daisy_delay: assert property (@(posedge sclk) disable iff (!rst_n)
        (frame_reg && word_seen_reg) |-> so_bit == $past(si_pin, 16))
        else $error("chain output is not the input delayed by one word");

    // ---------------- system domain ----------------
    logic            cs_sync1_reg;
    logic            cs_sync2_reg;
    logic            cs_sync3_reg;
    logic            pin_sync1_reg;
    logic            pin_sync2_reg;
    logic            temp_sync1_reg;
    logic            temp_sync2_reg;
    logic [CHANNELS-1:0] on_sync1_reg;
    logic [CHANNELS-1:0] on_sync2_reg;
    logic [CHANNELS-1:0] on_prev_reg;
    logic            cs_rise;
    logic            length_ok;
    logic            parity_ok;
    logic            word_ok;
    logic            wr_en;
    cmd_word_s       cmd;
    logic [3:0]      sel_reg;
    logic            pf_reg;
    logic            fault_read;
    logic [9:0]      mem_rd_data;
    logic [3:0]      mem_rd_addr;
    logic [CHANNELS-1:0] held_sign_reg;
    so_word_s        out_word_next;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            cs_sync1_reg   <= 1'b1;
            cs_sync2_reg   <= 1'b1;
            cs_sync3_reg   <= 1'b1;
            pin_sync1_reg  <= 1'b0;
            pin_sync2_reg  <= 1'b0;
            temp_sync1_reg <= 1'b0;
            temp_sync2_reg <= 1'b0;
            on_sync1_reg   <= '0;
            on_sync2_reg   <= '0;
            on_prev_reg    <= '0;
        end else begin
            cs_sync1_reg   <= chip_select_n;
            cs_sync2_reg   <= cs_sync1_reg;
            cs_sync3_reg   <= cs_sync2_reg;
            pin_sync1_reg  <= reset_n_pin;
            pin_sync2_reg  <= pin_sync1_reg;
            temp_sync1_reg <= temp_over_warn;
            temp_sync2_reg <= temp_sync1_reg;
            on_sync1_reg   <= channel_out_high;
            on_sync2_reg   <= on_sync1_reg;
            on_prev_reg    <= on_sync2_reg;
        end
    end

    // the link registers are read only after the synchronised rise, when the
    // serial clock has stopped and they are quiet
    assign cs_rise   = cs_sync2_reg & ~cs_sync3_reg;
    assign cmd       = cmd_word_s'(rx_sr_reg);
    assign length_ok = word_seen_reg && (bit_cnt_reg == 4'h0);
    assign parity_ok = ~^rx_sr_reg;
    assign word_ok   = length_ok && parity_ok && pin_sync2_reg;
    assign wr_en     = cs_rise && word_ok;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            cfg_write <= '0;
        end else begin
            cfg_write.strobe <= wr_en;
            cfg_write.bank   <= cmd.bank;
            cfg_write.addr   <= cmd.addr;
            cfg_write.data   <= cmd.payload;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            watchdog_toggle_bit <= 1'b0;
        end else if (!pin_sync2_reg) begin
            watchdog_toggle_bit <= 1'b0;
        end else if (wr_en) begin
            watchdog_toggle_bit <= cmd.wd;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            pf_reg <= 1'b0;
        end else if (cs_rise && length_ok) begin
            pf_reg <= ~parity_ok;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            sel_reg <= `SEL_RESET;
        end else if (!pin_sync2_reg) begin
            sel_reg <= `SEL_RESET;
        end else if (wr_en && cmd.addr == `CMD_ADDR_STATUS_REPORT_REG) begin
            sel_reg <= {cmd.bank, cmd.payload[2:0]};
        end
    end

    // input register slot is the output address minus one within a bank
    assign mem_rd_addr = {sel_reg[3], sel_reg[2:0] - 3'h1};

    cfg_reg_mem #(
        .AW (4),
        .DW (10)
    ) u_cfg_mem (
        .clk     (clk),
        .rst_n   (rst_n),
        .clr     (~pin_sync2_reg),
        .wr_en   (wr_en),
        .wr_addr ({cmd.bank, cmd.addr}),
        .wr_data (cmd.payload),
        .rd_addr (mem_rd_addr),
        .rd_data (mem_rd_data)
    );

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            offset_sign_select <= '0;
            track_hold_en      <= 1'b0;
        end else if (!pin_sync2_reg) begin
            offset_sign_select <= '0;
            track_hold_en      <= 1'b0;
        end else if (wr_en) begin
            if (cmd.addr == `CMD_ADDR_RETRY) begin
                offset_sign_select[cmd.bank] <= cmd.payload[`OFFSET_SIGN_POS];
            end
            if (cmd.addr == `CMD_ADDR_GCR && !cmd.bank) begin
                track_hold_en <= cmd.payload[`TRACK_HOLD_POS];
            end
        end
    end

    // held sign follows the live one while the channel conducts and freezes
    // at switch-off, so a change made while off cannot move the held value
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            held_sign_reg <= '0;
        end else begin
            for (int c = 0; c < CHANNELS; c++) begin
                if (on_sync2_reg[c]) begin
                    held_sign_reg[c] <= offset_sign_select[c];
                end
            end
        end
    end

    assign sense_offset_sign = track_hold_en ? held_sign_reg : offset_sign_select;

    // a read is the completion of a frame that shifted out a fault word
    assign fault_read = cs_rise && word_seen_reg && (sel_reg[2:0] == `SOA_FAULT_REPORT_REG);

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            temp_prewarning_flag <= 1'b0;
        end else if (normal_mode && temp_sync2_reg) begin
            temp_prewarning_flag <= 1'b1;
        end else if (fault_read) begin
            temp_prewarning_flag <= 1'b0;
        end
    end

    always_comb begin
        out_word_next      = '0;
        out_word_next.wd   = watchdog_toggle_bit;
        out_word_next.pf   = pf_reg;
        out_word_next.soa  = sel_reg;
        out_word_next.nm   = normal_mode;
        unique case (sel_reg[2:0])
            `SOA_STATUS_REPORT_REG:  out_word_next.data = {status_misc, on_sync2_reg};
            `SOA_FAULT_REPORT_REG: out_word_next.data = {temp_prewarning_flag, 2'b00,
                                               fault_bits[sel_reg[3]]};
            default:     out_word_next.data = mem_rd_data[8:0];
        endcase
    end

    // refreshed every idle cycle but the synchronised rise; frozen once chip select low is seen so the
    // link side shifts a steady word (a change in the first two cycles after
    // the fall is possible and is covered by the serial setup margin)
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            out_word_reg <= '0;
        end else if (cs_sync2_reg && !cs_rise) begin
            out_word_reg <= out_word_next;
        end
    end

    chk_length_reject: assert property (@(posedge clk) disable iff (!rst_n)
        (cs_rise && bit_cnt_reg != 4'h0) |-> !wr_en)
        else $error("write taken for a length that is not whole words");

    chk_parity_reject: assert property (@(posedge clk) disable iff (!rst_n)
        (cs_rise && ^rx_sr_reg) |-> !wr_en ##1 !cfg_write.strobe)
        else $error("write taken for a word with odd parity");

    chk_pin_blocks: assert property (@(posedge clk) disable iff (!rst_n)
        !pin_sync2_reg |-> !wr_en)
        else $error("write taken while the reset pin is low");

    chk_watchdog_cap: assert property (@(posedge clk) disable iff (!rst_n)
        (wr_en && pin_sync1_reg) |=> watchdog_toggle_bit == $past(rx_sr_reg[15]))
        else $error("watchdog bit not taken from word bit 15");

    chk_select_next: assert property (@(posedge clk) disable iff (!rst_n)
        (wr_en && cmd.addr == `CMD_ADDR_STATUS_REPORT_REG && pin_sync1_reg)
        |=> ##1 out_word_reg.soa == $past(sel_reg) || !cs_sync2_reg)
        else $error("output word does not follow the new selection");

    chk_sign_write: assert property (@(posedge clk) disable iff (!rst_n)
        (wr_en && cmd.addr == `CMD_ADDR_RETRY && pin_sync1_reg)
        |=> offset_sign_select[$past(cmd.bank)] == $past(rx_sr_reg[8]))
        else $error("offset sign not taken from payload bit 8");

    chk_warn_set: assert property (@(posedge clk) disable iff (!rst_n)
        (normal_mode && temp_sync2_reg) |=> temp_prewarning_flag)
        else $error("prewarning flag not set while over threshold");

    chk_warn_hold: assert property (@(posedge clk) disable iff (!rst_n)
        (temp_prewarning_flag && !fault_read) |=> temp_prewarning_flag)
        else $error("prewarning flag cleared without a fault report read");

    chk_held_sign: assert property (@(posedge clk) disable iff (!rst_n)
        (!on_sync2_reg[0] && !on_prev_reg[0]) |=> $stable(held_sign_reg[0]))
        else $error("held offset sign moved while channel 0 is off");

    chk_out_float: assert property (@(posedge clk) disable iff (!rst_n)
        chip_select_n |-> !so_oe)
        else $error("serial output driven with chip select high");
endmodule

// ===== rtl/switch_port_regs.svh
// bit positions, addresses and reset values of the switch command port
`ifndef SWITCH_PORT_REGS_SVH
`define SWITCH_PORT_REGS_SVH

`define WORD_BITS        16
`define CMD_ADDR_STATUS_REPORT_REG   3'h0
`define CMD_ADDR_PWMR    3'h1
`define CMD_ADDR_CONFR   3'h2
`define CMD_ADDR_OCR     3'h3
`define CMD_ADDR_RETRY   3'h4
`define CMD_ADDR_GCR     3'h6
`define SOA_STATUS_REPORT_REG        3'h0
`define SOA_FAULT_REPORT_REG       3'h1
`define OFFSET_SIGN_POS  8
`define TRACK_HOLD_POS   5
`define CFG_RESET        10'h000
`define SEL_RESET        4'h0

`endif

// ===== rtl/switch_port_pkg.sv
// types shared by the switch command port
package switch_port_pkg;

    typedef struct packed {
        logic       wd;
        logic       parity;
        logic       bank;
        logic [2:0] addr;
        logic [9:0] payload;
    } cmd_word_s;

    typedef struct packed {
        logic       wd;
        logic       pf;
        logic [3:0] soa;
        logic       nm;
        logic [8:0] data;
    } so_word_s;

    typedef struct packed {
        logic       strobe;
        logic       bank;
        logic [2:0] addr;
        logic [9:0] data;
    } cfg_write_s;

endpackage

// ===== rtl/cfg_reg_mem.sv
// small register bank holding the configuration words, registered read
`timescale 1ns/1ps
module cfg_reg_mem #(
    parameter int AW = 4,
    parameter int DW = 10
) (
    input  wire logic          clk,
    input  wire logic          rst_n,
    input  wire logic          clr,
    input  wire logic          wr_en,
    input  wire logic [AW-1:0] wr_addr,
    input  wire logic [DW-1:0] wr_data,
    input  wire logic [AW-1:0] rd_addr,
    output logic      [DW-1:0] rd_data
);
    logic [DW-1:0] mem_reg [2**AW];

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            for (int i = 0; i < 2**AW; i++) mem_reg[i] <= '0;
        end else if (clr) begin
            for (int i = 0; i < 2**AW; i++) mem_reg[i] <= '0;
        end else if (wr_en) begin
            mem_reg[wr_addr] <= wr_data;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            rd_data <= '0;
        end else begin
            rd_data <= mem_reg[rd_addr];
        end
    end
endmodule

// ===== bench/spi_master_model.sv
// serial bus master model that drives the command port link
`timescale 1ns/1ps
module spi_master_model (
    output logic      sclk,
    output logic      chip_select_n,
    output logic      si_pin,
    input  wire logic so_line
);
    initial begin
        sclk = 1'b0;
        chip_select_n = 1'b1;
        si_pin = 1'b0;
    end

    // lengths other than a multiple of 16 are sent only when a frame is meant to be refused
    task automatic frame(input logic [31:0] tx, input int n, output logic [31:0] rx);
        rx = '0;
        chip_select_n = 1'b0;
        #15;
        for (int i = n - 1; i >= 0; i--) begin
            rx = {rx[30:0], so_line};
            si_pin = tx[i];
            #15 sclk = 1'b1;
            #15 sclk = 1'b0;
        end
        #15 chip_select_n = 1'b1;
        // released data line must not keep showing the last bit
        si_pin = ~si_pin;
    endtask
endmodule

// ===== bench/spi_switch_command_port_tb.sv
// self-checking bench for the switch command port
`timescale 1ns/1ps
`include "switch_port_regs.svh"
module spi_switch_command_port_tb
    import switch_port_pkg::*;
;
    logic        clk = 1'b0;
    logic        rst_n = 1'b0;
    logic        reset_n_pin = 1'b1;
    logic        normal_mode = 1'b0;
    logic        temp_over_warn = 1'b0;
    logic [1:0]  channel_out_high = 2'b10;
    logic [6:0]  status_misc = 7'h55;
    logic [5:0]  fault_bits [2] = '{6'h2a, 6'h15};
    logic        sclk, chip_select_n, si_pin, so_out, so_oe;
    logic        watchdog_toggle_bit, temp_prewarning_flag, track_hold_en;
    logic [1:0]  offset_sign_select, sense_offset_sign;
    cfg_write_s  cfg_write, last_wr;
    logic [31:0] rx;
    int          errors = 0;
    int          n_compared = 0;
    int          n_wr = 0;
    int          k;
    wire         so_line = so_oe ? so_out : 1'bz;

    always #2 clk = ~clk;

    always @(posedge clk) begin
        if (cfg_write.strobe === 1'b1) begin
            last_wr <= cfg_write;
            n_wr <= n_wr + 1;
        end
    end

    spi_switch_command_port uut (.clk(clk), .rst_n(rst_n), .sclk(sclk),
        .chip_select_n(chip_select_n), .si_pin(si_pin), .so_out(so_out), .so_oe(so_oe),
        .reset_n_pin(reset_n_pin), .normal_mode(normal_mode), .temp_over_warn(temp_over_warn),
        .channel_out_high(channel_out_high), .status_misc(status_misc),
        .fault_bits(fault_bits), .watchdog_toggle_bit(watchdog_toggle_bit),
        .temp_prewarning_flag(temp_prewarning_flag), .offset_sign_select(offset_sign_select),
        .sense_offset_sign(sense_offset_sign), .track_hold_en(track_hold_en),
        .cfg_write(cfg_write));

    spi_master_model m (.sclk(sclk), .chip_select_n(chip_select_n), .si_pin(si_pin),
        .so_line(so_line));

    function automatic logic [15:0] cmd(logic wd, logic bank, logic [2:0] a, logic [9:0] pl);
        cmd_word_s w;
        w = '{wd, 1'b0, bank, a, pl};
        w.parity = ^w;
        return w;
    endfunction

    function automatic logic [14:0] ow(logic pf, logic [3:0] sel, logic [8:0] d);
        return {pf, sel, normal_mode, d};
    endfunction

    task automatic chk(string what, logic [31:0] seen, logic [31:0] exp);
        n_compared++;
        if (seen !== exp) begin
            errors++;
            $display("ERROR %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic finish_test();
        $display("compared %0d errors %0d", n_compared, errors);
        if (errors == 0 && n_compared > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask

    // cs high for 12 clocks leaves room for the write and the output refresh
    task automatic xf(logic [31:0] tx, int n = 16);
        m.frame(tx, n, rx);
        repeat (12) @(negedge clk);
        chk("so_oe idle", so_oe, 0);
    endtask

    initial begin
        #200000;
        chk("timeout", 1, 0);
        finish_test();
    end

    initial begin
        repeat (4) @(negedge clk);
        rst_n = 1'b1;
        repeat (4) @(negedge clk);
        chk("reset outs", {watchdog_toggle_bit, temp_prewarning_flag, offset_sign_select,
            track_hold_en, cfg_write}, 0);
        xf(cmd(0, 0, `CMD_ADDR_RETRY, 10'h105));
        chk("status word", rx[14:0], ow(0, 4'h0, {7'h55, 2'b10}));
        chk("sign ch0", offset_sign_select, 2'b01);
        chk("write", last_wr, {1'b1, 1'b0, `CMD_ADDR_RETRY, 10'h105});
        xf(cmd(0, 1, `CMD_ADDR_RETRY, 10'h100));
        chk("sign ch1", offset_sign_select, 2'b11);
        xf(cmd(0, 0, `CMD_ADDR_STATUS_REPORT_REG, 10'h005));
        xf({cmd(1, 0, `CMD_ADDR_RETRY, 10'h005), cmd(0, 1, `CMD_ADDR_RETRY, 10'h000)}, 32);
        chk("chain word0", rx[30:16], ow(0, 4'h5, 9'h105));
        chk("chain word1", rx[15:0], cmd(1, 0, `CMD_ADDR_RETRY, 10'h005));
        chk("last word only", offset_sign_select, 2'b01);
        chk("wd first word", watchdog_toggle_bit, 0);
        xf(cmd(0, 0, `CMD_ADDR_RETRY, 10'h000) ^ 32'h0000_4000);
        chk("bad parity", offset_sign_select, 2'b01);
        xf(cmd(0, 0, `CMD_ADDR_STATUS_REPORT_REG, 10'h001));
        chk("parity flag", rx[14:0], ow(1, 4'h5, 9'h105));
        k = n_wr;
        foreach (fault_bits[i]) begin
            xf(cmd(0, 0, `CMD_ADDR_RETRY, 10'h000), 15 + 2 * i);
        end
        chk("bad length", offset_sign_select, 2'b01);
        chk("no write", n_wr, k);
        xf(cmd(1, 0, `CMD_ADDR_STATUS_REPORT_REG, 10'h001));
        chk("wd set", watchdog_toggle_bit, 1);
        xf(cmd(0, 0, `CMD_ADDR_STATUS_REPORT_REG, 10'h001));
        chk("wd echo", rx[15], 1);
        chk("wd clear", watchdog_toggle_bit, 0);
        normal_mode = 1'b1;
        temp_over_warn = 1'b1;
        repeat (5) @(negedge clk);
        chk("warn set", temp_prewarning_flag, 1);
        xf(cmd(0, 0, `CMD_ADDR_STATUS_REPORT_REG, 10'h001));
        chk("fault word", rx[14:0], ow(0, 4'h1, {3'b100, 6'h2a}));
        chk("warn kept", temp_prewarning_flag, 1);
        temp_over_warn = 1'b0;
        repeat (5) @(negedge clk);
        chk("warn sticky", temp_prewarning_flag, 1);
        xf(cmd(0, 0, `CMD_ADDR_STATUS_REPORT_REG, 10'h001));
        chk("warn cleared", temp_prewarning_flag, 0);
        xf(cmd(0, 0, `CMD_ADDR_GCR, 10'h020));
        chk("track hold", track_hold_en, 1);
        channel_out_high = 2'b11;
        repeat (5) @(negedge clk);
        chk("sign live", sense_offset_sign[0], 1);
        channel_out_high = 2'b10;
        repeat (5) @(negedge clk);
        xf(cmd(0, 0, `CMD_ADDR_RETRY, 10'h000));
        chk("sign reg", offset_sign_select[0], 0);
        chk("sign held", sense_offset_sign[0], 1);
        channel_out_high = 2'b11;
        repeat (5) @(negedge clk);
        chk("sign renewed", sense_offset_sign[0], 0);
        reset_n_pin = 1'b0;
        repeat (5) @(negedge clk);
        chk("pin reset", {offset_sign_select, track_hold_en}, 0);
        xf(cmd(0, 0, `CMD_ADDR_RETRY, 10'h100));
        chk("pin blocks", offset_sign_select, 2'b00);
        reset_n_pin = 1'b1;
        finish_test();
    end
endmodule
